//--- rtl/cmp_ctrl_pkg.sv
// Package: register map, field layouts and types of the comparator control
package cmp_ctrl_pkg;
   // ==========================================================
   // Register offsets (byte addresses)
   localparam logic [7:0] OFS_CTRL1 = 8'h00;
   localparam logic [7:0] OFS_CTRL2 = 8'h04;
   localparam logic [7:0] OFS_STAT = 8'h08;
   localparam logic [7:0] OFS_FLAG = 8'h0c;
   localparam logic [7:0] OFS_ENAB = 8'h10;
   localparam logic [7:0] OFS_IRQC = 8'h14;
   // ==========================================================
   // Field positions and reset values
   localparam int FLAG_LSB = 5;
   localparam int PERIPHERAL_IRQ_ENABLE_BIT = 6;
   localparam int GIE_BIT = 7;
   localparam logic [7:0] CTRL_RST = 8'h1f;
   localparam logic [1:0] FLAG_RST = 2'h0;
   localparam logic [1:0] ENAB_RST = 2'h0;
   localparam int SYNC_STAGES = 3;
   // ==========================================================
   // Encodings
   localparam logic [1:0] EV_NONE = 2'h0;
   localparam logic [1:0] EV_RISE = 2'h1;
   localparam logic [1:0] EV_FALL = 2'h2;
   localparam logic [1:0] EV_ANY = 2'h3;
   localparam logic [1:0] NEG_B = 2'h0;
   localparam logic [1:0] NEG_C = 2'h1;
   localparam logic [1:0] NEG_D = 2'h2;
   localparam logic [1:0] NEG_FIXED = 2'h3;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // ==========================================================
   // Types
   typedef struct packed {
      logic comparator_on_bit;
      logic pin_output_route;
      logic output_invert;
      logic [1:0] event_select;
      logic positive_ref_select;
      logic [1:0] negative_channel_select;
   } comparator_control_t;
   typedef struct packed {
      logic power;
      logic pos_ladder;
      logic [3:0] neg_onehot;
   } analog_route_t;
endpackage : cmp_ctrl_pkg

//--- rtl/dual_comparator_control.sv
// Digital control, result capture and event flags of two comparators
`timescale 1ns/100ps
module dual_comparator_control #(
   parameter bit LARGE_PACKAGE = 1'b1
) (
   input wire logic core_clk,
   input wire logic srst,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [1:0] comparator_raw,
   input wire logic [1:0] port_latch,
   input wire logic [1:0] port_direction,
   output cmp_ctrl_pkg::analog_route_t route_o [2],
   output logic [1:0] pin_out,
   output logic [1:0] pin_out_en,
   output logic irq
);
   import cmp_ctrl_pkg::*;

   // ==========================================================
   // Write channel capture
   logic aw_held_q;
   logic w_held_q;
   logic [7:0] waddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic wr_go;
   logic wr_hit;
   logic [7:0] wb;

   assign wr_go = aw_held_q && w_held_q && !s_axi_bvalid;
   assign wb = wdata_q[7:0];
   assign wr_hit = waddr_q == OFS_CTRL1 || waddr_q == OFS_CTRL2 ||
                   waddr_q == OFS_STAT || waddr_q == OFS_FLAG ||
                   waddr_q == OFS_ENAB || waddr_q == OFS_IRQC;

   always_ff @(posedge core_clk) begin
      if (srst) begin
         aw_held_q <= 1'b0;
         waddr_q <= 8'h00;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held_q <= 1'b1;
         waddr_q <= s_axi_awaddr;
      end else if (wr_go) begin
         aw_held_q <= 1'b0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         w_held_q <= 1'b0;
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held_q <= 1'b1;
         wdata_q <= s_axi_wdata;
         wstrb_q <= s_axi_wstrb;
      end else if (wr_go) begin
         w_held_q <= 1'b0;
      end
   end

   // Ready is a flop; one write is in flight at most
   always_ff @(posedge core_clk) begin
      if (srst) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
      end else begin
         s_axi_awready <= !aw_held_q && !s_axi_awready &&
                          !s_axi_bvalid;
         s_axi_wready <= !w_held_q && !s_axi_wready && !s_axi_bvalid;
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else if (wr_go) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Only byte lane 0 carries register bits
   logic wr_en;
   assign wr_en = wr_go && wstrb_q[0];

   // ==========================================================
   // Control and interrupt registers
   comparator_control_t ctrl_q [2];
   logic [1:0] flag_q;
   logic [1:0] enab_q;
   logic peripheral_irq_enable_q;
   logic gie_q;

   always_ff @(posedge core_clk) begin
      if (srst) begin
         ctrl_q[0] <= CTRL_RST;
         ctrl_q[1] <= CTRL_RST;
      end else if (wr_en && waddr_q == OFS_CTRL1) begin
         ctrl_q[0] <= wb;
      end else if (wr_en && waddr_q == OFS_CTRL2) begin
         ctrl_q[1] <= wb;
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         enab_q <= ENAB_RST;
         peripheral_irq_enable_q <= 1'b0;
         gie_q <= 1'b0;
      end else if (wr_en && waddr_q == OFS_ENAB) begin
         enab_q <= wb[FLAG_LSB +: 2];
      end else if (wr_en && waddr_q == OFS_IRQC) begin
         peripheral_irq_enable_q <= wb[PERIPHERAL_IRQ_ENABLE_BIT];
         gie_q <= wb[GIE_BIT];
      end
   end

   // ==========================================================
   // Per comparator: synchroniser, gating, polarity, events
   logic [SYNC_STAGES-1:0] sync_q [2];
   logic [1:0] res_q;
   logic [1:0] adj;
   logic [1:0] adj_prev_q;
   logic [1:0] event_hit;
   logic [1:0] arm_any;

   for (genvar i = 0; i < 2; i++) begin : g_cmp
      logic rise;
      logic fall;

      always_ff @(posedge core_clk) begin
         if (srst) begin
            sync_q[i] <= '0;
         end else begin
            sync_q[i] <= {sync_q[i][1:0], comparator_raw[i]};
         end
      end

      // A new level counts once stages two and three agree
      always_ff @(posedge core_clk) begin
         if (srst) begin
            res_q[i] <= 1'b0;
         end else if (!ctrl_q[i].comparator_on_bit) begin
            res_q[i] <= 1'b0;
         end else if (sync_q[i][1] == sync_q[i][2]) begin
            res_q[i] <= sync_q[i][2];
         end
      end

      assign adj[i] = res_q[i] ^ ctrl_q[i].output_invert;
      assign rise = adj[i] && !adj_prev_q[i];
      assign fall = !adj[i] && adj_prev_q[i];

      always_comb begin
         unique case (ctrl_q[i].event_select)
            EV_NONE: event_hit[i] = 1'b0;
            EV_RISE: event_hit[i] = rise;
            EV_FALL: event_hit[i] = fall;
            EV_ANY: event_hit[i] = rise || fall;
         endcase
      end

      // Selecting any-change mode raises the flag on the write itself
      assign arm_any[i] = wr_en &&
         waddr_q == (i == 0 ? OFS_CTRL1 : OFS_CTRL2) &&
         wb[4:3] == EV_ANY;

      always_ff @(posedge core_clk) begin
         if (srst) begin
            adj_prev_q[i] <= 1'b0;
         end else begin
            adj_prev_q[i] <= adj[i];
         end
      end

      // Channels C and D exist only on the larger package, and D only
      // on the second comparator; an absent choice connects nothing
      always_ff @(posedge core_clk) begin
         if (srst) begin
            route_o[i] <= '0;
         end else begin
            route_o[i].power <= ctrl_q[i].comparator_on_bit;
            route_o[i].pos_ladder <=
               ctrl_q[i].positive_ref_select;
            route_o[i].neg_onehot <= '0;
            unique case (ctrl_q[i].negative_channel_select)
               NEG_B: route_o[i].neg_onehot[0] <= 1'b1;
               NEG_C: route_o[i].neg_onehot[1] <= LARGE_PACKAGE;
               NEG_D: route_o[i].neg_onehot[2] <=
                  LARGE_PACKAGE && i == 1;
               NEG_FIXED: route_o[i].neg_onehot[3] <= 1'b1;
            endcase
         end
      end

      always_ff @(posedge core_clk) begin
         if (srst) begin
            pin_out[i] <= 1'b0;
            pin_out_en[i] <= 1'b0;
         end else begin
            pin_out[i] <= ctrl_q[i].pin_output_route ?
                          adj[i] : port_latch[i];
            pin_out_en[i] <= !port_direction[i];
         end
      end
   end

   // ==========================================================
   // Event flags: hardware set wins over a software clear
   logic [1:0] flag_wr;
   assign flag_wr = wb[FLAG_LSB +: 2];

   always_ff @(posedge core_clk) begin
      if (srst) begin
         flag_q <= FLAG_RST;
      end else if (wr_en && waddr_q == OFS_FLAG) begin
         flag_q <= flag_wr | event_hit | arm_any;
      end else begin
         flag_q <= flag_q | event_hit | arm_any;
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         irq <= 1'b0;
      end else begin
         irq <= |(flag_q & enab_q) && peripheral_irq_enable_q && gie_q;
      end
   end

   // ==========================================================
   // Read channel; status ignores writes entirely
   logic [7:0] rd_byte;
   logic rd_hit;

   always_comb begin
      rd_hit = 1'b1;
      unique case (s_axi_araddr)
         OFS_CTRL1: rd_byte = ctrl_q[0];
         OFS_CTRL2: rd_byte = ctrl_q[1];
         OFS_STAT: rd_byte = {6'h00, adj};
         OFS_FLAG: rd_byte = {1'b0, flag_q, 5'h00};
         OFS_ENAB: rd_byte = {1'b0, enab_q, 5'h00};
         OFS_IRQC: rd_byte = {gie_q, peripheral_irq_enable_q, 6'h00};
         default: begin
            rd_byte = 8'h00;
            rd_hit = 1'b0;
         end
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         s_axi_arready <= 1'b0;
      end else begin
         s_axi_arready <= !s_axi_arready && !s_axi_rvalid &&
                          s_axi_arvalid;
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= {24'h00_0000, rd_byte};
         s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ==========================================================
   // Assertions
   property p_power;
      @(posedge core_clk) disable iff (srst)
      !ctrl_q[0].comparator_on_bit |=> !route_o[0].power;
   endproperty
   a_power: assert property (p_power)
      else $error("comparator powered while disabled");

   property p_neg_fixed;
      @(posedge core_clk) disable iff (srst)
      !srst && ctrl_q[1].negative_channel_select == NEG_FIXED
         |=> route_o[1].neg_onehot == 4'h8;
   endproperty
   a_neg_fixed: assert property (p_neg_fixed)
      else $error("fixed reference not routed");

   property p_pos_ref;
      @(posedge core_clk) disable iff (srst)
      !srst |=> route_o[0].pos_ladder ==
         $past(ctrl_q[0].positive_ref_select);
   endproperty
   a_pos_ref: assert property (p_pos_ref)
      else $error("positive input route wrong");

   property p_off_zero;
      @(posedge core_clk) disable iff (srst)
      !ctrl_q[1].comparator_on_bit ##1 !ctrl_q[1].comparator_on_bit
         |-> adj[1] == ctrl_q[1].output_invert;
   endproperty
   a_off_zero: assert property (p_off_zero)
      else $error("disabled result not held low");

   property p_pin_mux;
      @(posedge core_clk) disable iff (srst)
      ctrl_q[0].pin_output_route |=> pin_out[0] == $past(adj[0]);
   endproperty
   a_pin_mux: assert property (p_pin_mux)
      else $error("pin does not carry result");

   property p_pin_oe;
      @(posedge core_clk) disable iff (srst)
      !srst |=> pin_out_en == ~$past(port_direction);
   endproperty
   a_pin_oe: assert property (p_pin_oe)
      else $error("pin enable not from direction");

   property p_rise;
      @(posedge core_clk) disable iff (srst)
      ctrl_q[0].event_select == EV_RISE && $rose(adj[0])
         |=> flag_q[0];
   endproperty
   a_rise: assert property (p_rise)
      else $error("rising change not flagged");

   property p_none;
      @(posedge core_clk) disable iff (srst)
      ctrl_q[0].event_select == EV_NONE && !flag_q[0] && !wr_go
         |=> !flag_q[0];
   endproperty
   a_none: assert property (p_none)
      else $error("flag set with events disabled");

   property p_sticky;
      @(posedge core_clk) disable iff (srst)
      flag_q[1] && !(wr_en && waddr_q == OFS_FLAG) |=> flag_q[1];
   endproperty
   a_sticky: assert property (p_sticky)
      else $error("flag cleared without a write");

   property p_irq;
      @(posedge core_clk) disable iff (srst)
      1'b1 |=> irq == ($past(|(flag_q & enab_q)) &&
                       $past(peripheral_irq_enable_q) && $past(gie_q));
   endproperty
   a_irq: assert property (p_irq)
      else $error("interrupt gating wrong");

   property p_sync;
      @(posedge core_clk) disable iff (srst)
      ctrl_q[0].comparator_on_bit && $changed(res_q[0])
         |-> $past(sync_q[0][2]) == $past(sync_q[0][1]);
   endproperty
   a_sync: assert property (p_sync)
      else $error("result taken before stages agree");

   c_any: cover property (@(posedge core_clk)
      ctrl_q[1].event_select == EV_ANY && $fell(adj[1]));
   c_irq: cover property (@(posedge core_clk) $rose(irq));
   c_wr: cover property (@(posedge core_clk)
      s_axi_bvalid && s_axi_bready);
endmodule : dual_comparator_control

//--- test/analog_front_model.sv
// Behavioural model of the two analog comparator cores and their input pins
`timescale 1ns/100ps
module analog_front_model (
   input wire logic core_clk,
   input wire cmp_ctrl_pkg::analog_route_t route [2],
   input wire logic [1:0][11:0] pin_a_mv,
   input wire logic [1:0][11:0] pin_b_mv,
   input wire logic [1:0][11:0] pin_c_mv,
   input wire logic [1:0][11:0] pin_d_mv,
   input wire logic [11:0] ladder_mv,
   input wire logic [11:0] fixed_mv,
   output logic [1:0] comparator_raw
);
   import cmp_ctrl_pkg::*;
   // ==========
   // Cores
   // Unpowered core output wanders, so the control logic must mask it
   logic [1:0] wander_q = 2'h1;
   always_ff @(posedge core_clk) begin
      wander_q <= ~wander_q;
   end
   for (genvar i = 0; i < 2; i++) begin : g_core
      logic [11:0] plus_mv;
      logic [11:0] minus_mv;
      logic hooked;
      assign plus_mv = route[i].pos_ladder ? ladder_mv : pin_a_mv[i];
      always_comb begin
         hooked = 1'b1;
         case (route[i].neg_onehot)
            4'h1: minus_mv = pin_b_mv[i];
            4'h2: minus_mv = pin_c_mv[i];
            4'h4: minus_mv = pin_d_mv[i];
            4'h8: minus_mv = fixed_mv;
            default: begin
               minus_mv = 12'h000;
               hooked = 1'b0;
            end
         endcase
      end
      // An open inverting input gives no trustworthy level either
      assign comparator_raw[i] = (route[i].power && hooked) ?
         (plus_mv > minus_mv) : wander_q[i];
   end
endmodule : analog_front_model

//--- test/testbench.sv
// Self-checking testbench of the dual comparator control block
`timescale 1ns/100ps
module testbench;
   import cmp_ctrl_pkg::*;
   // ==========
   // Signals
   logic core_clk, srst;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic s_axi_rvalid, s_axi_rready;
   logic [1:0] comparator_raw, port_latch, port_direction;
   analog_route_t route_o [2];
   logic [1:0] pin_out, pin_out_en;
   logic irq;
   logic [1:0][11:0] pin_a_mv, pin_b_mv, pin_c_mv, pin_d_mv;
   logic [11:0] ladder_mv, fixed_mv;
   int n_mismatch = 0;
   int comparisons = 0;
   // ==========
   // Instances
   dual_comparator_control #(.LARGE_PACKAGE(1'b1)) DUT (
      .core_clk(core_clk), .srst(srst),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .comparator_raw(comparator_raw),
      .port_latch(port_latch), .port_direction(port_direction),
      .route_o(route_o), .pin_out(pin_out), .pin_out_en(pin_out_en),
      .irq(irq));
   analog_front_model u_front (
      .core_clk(core_clk), .route(route_o), .pin_a_mv(pin_a_mv),
      .pin_b_mv(pin_b_mv), .pin_c_mv(pin_c_mv), .pin_d_mv(pin_d_mv),
      .ladder_mv(ladder_mv), .fixed_mv(fixed_mv),
      .comparator_raw(comparator_raw));
   // ==========
   // Clock and watchdog
   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end
   initial begin
      repeat (20000) @(posedge core_clk);
      n_mismatch++;
      give_verdict();
   end
   // ==========
   // Tasks
   task automatic give_verdict();
      if (n_mismatch == 0 && comparisons > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : give_verdict
   task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_reg
   task automatic chk_sig(input logic [7:0] got, input logic [7:0] exp);
      chk_reg({24'h0, got}, {24'h0, exp});
   endtask : chk_sig
   task automatic w(input int n);
      repeat (n) @(posedge core_clk);
   endtask : w
   // Bready is held high, so a new write may start at the response edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d,
                     input logic [1:0] er = RESP_OKAY);
      int t;
      t = 0;
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do begin
         @(posedge core_clk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         t++;
      end while (s_axi_bvalid !== 1'b1 && t < 50);
      if (t >= 50) n_mismatch++;
      chk_sig({6'h0, s_axi_bresp}, {6'h0, er});
   endtask : wr
   task automatic rc(input logic [7:0] a, input logic [7:0] e,
                     input logic [1:0] er = RESP_OKAY);
      int t;
      t = 0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do begin
         @(posedge core_clk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         t++;
      end while (s_axi_rvalid !== 1'b1 && t < 50);
      if (t >= 50) n_mismatch++;
      chk_reg(s_axi_rdata, {24'h0, e});
      chk_sig({6'h0, s_axi_rresp}, {6'h0, er});
   endtask : rc
   // ==========
   // Tests
   initial begin
      srst = 1'b1;
      {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 3'h0;
      {s_axi_bready, s_axi_rready} = 2'h3;
      s_axi_awaddr = 8'h00;
      s_axi_araddr = 8'h00;
      s_axi_wdata = 32'h0;
      s_axi_wstrb = 4'h1;
      port_latch = 2'h0;
      port_direction = 2'h0;
      pin_a_mv = {12'h12c, 12'h384};
      pin_b_mv = {12'h1f4, 12'h1f4};
      pin_c_mv = {12'h2bc, 12'h2bc};
      pin_d_mv = {12'h320, 12'h320};
      ladder_mv = 12'h3e8;
      fixed_mv = 12'h4b0;
      repeat (8) @(posedge core_clk);
      srst <= 1'b0;
      @(posedge core_clk);
      rc(OFS_CTRL1, CTRL_RST);
      rc(OFS_CTRL2, CTRL_RST);
      rc(OFS_FLAG, 8'h00);
      chk_sig({6'h0, route_o[1].power, route_o[0].power}, 8'h00);
      rc(OFS_STAT, 8'h00);
      wr(8'h18, 8'h55, RESP_SLVERR);
      rc(8'h18, 8'h00, RESP_SLVERR);
      wr(OFS_CTRL1, 8'h20);
      w(8);
      rc(OFS_STAT, 8'h01);
      wr(OFS_CTRL1, 8'h82);
      w(2);
      chk_sig({4'h0, route_o[0].neg_onehot}, 8'h00);
      wr(OFS_CTRL1, 8'h80);
      w(8);
      rc(OFS_STAT, 8'h01);
      chk_sig({route_o[0].power, route_o[0].pos_ladder, 2'h0,
               route_o[0].neg_onehot}, 8'h81);
      for (int s = 0; s < 4; s++) begin
         wr(OFS_CTRL2, 8'h84 | 8'(s));
         w(2);
         chk_sig({route_o[1].power, route_o[1].pos_ladder, 2'h0,
                  route_o[1].neg_onehot}, 8'hc0 | (8'h1 << s));
      end
      w(8);
      rc(OFS_STAT, 8'h01);
      ladder_mv <= 12'h5dc;
      w(8);
      rc(OFS_STAT, 8'h03);
      wr(OFS_STAT, 8'h00);
      s_axi_wstrb <= 4'h0;
      wr(OFS_CTRL2, 8'h00);
      s_axi_wstrb <= 4'h1;
      rc(OFS_CTRL2, 8'h87);
      rc(OFS_STAT, 8'h03);
      port_latch <= 2'h2;
      port_direction <= 2'h2;
      wr(OFS_CTRL1, 8'hc0);
      w(3);
      chk_sig({6'h0, pin_out}, 8'h03);
      chk_sig({6'h0, pin_out_en}, 8'h01);
      wr(OFS_CTRL1, 8'he0);
      w(8);
      chk_sig({6'h0, pin_out}, 8'h02);
      rc(OFS_STAT, 8'h02);
      wr(OFS_CTRL1, 8'h80);
      port_latch <= 2'h1;
      w(3);
      chk_sig({6'h0, pin_out}, 8'h01);
      pin_a_mv[0] <= 12'h12c;
      w(8);
      // Rising then falling result under every event selection
      for (int e = 0; e < 4; e++) begin
         wr(OFS_CTRL1, 8'h80 | 8'(e << 3));
         wr(OFS_FLAG, 8'h00);
         pin_a_mv[0] <= 12'h384;
         w(8);
         rc(OFS_FLAG, e[0] ? 8'h20 : 8'h00);
         chk_sig({7'h0, irq}, 8'h00);
         wr(OFS_FLAG, 8'h00);
         pin_a_mv[0] <= 12'h12c;
         w(8);
         rc(OFS_FLAG, e[1] ? 8'h20 : 8'h00);
      end
      // Inverted result: the invert write itself is a rising change
      wr(OFS_CTRL1, 8'ha8);
      wr(OFS_FLAG, 8'h00);
      pin_a_mv[0] <= 12'h384;
      w(8);
      rc(OFS_FLAG, 8'h00);
      pin_a_mv[0] <= 12'h12c;
      w(8);
      rc(OFS_FLAG, 8'h20);
      wr(OFS_CTRL1, 8'h80);
      wr(OFS_FLAG, 8'h00);
      wr(OFS_CTRL1, 8'h98);
      rc(OFS_FLAG, 8'h20);
      wr(OFS_FLAG, 8'h60);
      rc(OFS_FLAG, 8'h60);
      wr(OFS_ENAB, 8'h40);
      wr(OFS_IRQC, 8'h80);
      w(3);
      chk_sig({7'h0, irq}, 8'h00);
      wr(OFS_IRQC, 8'hc0);
      rc(OFS_IRQC, 8'hc0);
      rc(OFS_ENAB, 8'h40);
      chk_sig({7'h0, irq}, 8'h01);
      wr(OFS_FLAG, 8'h20);
      w(3);
      chk_sig({7'h0, irq}, 8'h00);
      rc(OFS_FLAG, 8'h20);
      srst <= 1'b1;
      w(2);
      srst <= 1'b0;
      w(1);
      rc(OFS_CTRL1, CTRL_RST);
      chk_sig({6'h0, route_o[1].power, route_o[0].power}, 8'h00);
      give_verdict();
   end
endmodule : testbench
